//--- hdl/frame_sync_pkg.sv
// Package for the frame synchronisation block: register map, field widths, modes.
// Assumes one 10 MHz clock domain and a plain strobe register port.
package frame_sync_pkg;

  localparam int unsigned ADDR_W   = 4;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned PIX_W    = 8;
  localparam int unsigned LINE_W   = 16;
  localparam int unsigned ACC_W    = 16;
  localparam int unsigned NSRC     = 6;
  localparam int unsigned DEB_W    = 2;

  localparam logic [ADDR_W-1:0] REG_CTRL     = 4'h0;
  localparam logic [ADDR_W-1:0] REG_AFTER    = 4'h1;
  localparam logic [ADDR_W-1:0] REG_MAXLINES = 4'h2;
  localparam logic [ADDR_W-1:0] REG_ROI      = 4'h3;
  localparam logic [ADDR_W-1:0] REG_LEVELS   = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STATUS   = 4'h5;

  localparam logic [LINE_W-1:0] MAXLINES_RST = 16'hffff;
  localparam logic [LINE_W-1:0] ROI_START_RST = 16'h0001;
  localparam logic [PIX_W-1:0]  RISE_RST     = 8'h80;
  localparam logic [PIX_W-1:0]  FALL_RST     = 8'h40;
  localparam logic [PIX_W-1:0]  LEVEL_MIN    = 8'h01;
  localparam logic [PIX_W-1:0]  LEVEL_MAX    = 8'hfe;
  localparam logic [2:0]        SRC_INTERNAL = 3'h4;

  // Debounce lengths in lines for levels 0..3.
  localparam logic [3:0] DEB_LEN0 = 4'h0;
  localparam logic [3:0] DEB_LEN1 = 4'h2;
  localparam logic [3:0] DEB_LEN2 = 4'h4;
  localparam logic [3:0] DEB_LEN3 = 4'h8;

  typedef enum logic [1:0] {
    MODE_FREE  = 2'h0,
    MODE_START = 2'h1,
    MODE_RSVD  = 2'h2,
    MODE_SS    = 2'h3
  } scan_mode_t;

  typedef enum logic [1:0] {
    ROI_32  = 2'h0,
    ROI_64  = 2'h1,
    ROI_128 = 2'h2,
    ROI_256 = 2'h3
  } roi_len_t;

  typedef struct packed {
    logic               trig_low_active;
    logic               max_stop_en;
    logic [DEB_W-1:0]   debounce;
    logic [2:0]         source;
    scan_mode_t         mode;
  } ctrl_t;

  typedef struct packed {
    logic             valid;
    logic             line_start;
    logic [PIX_W-1:0] data;
  } pixel_t;

endpackage

//--- hdl/frame_trigger_ctrl.sv
// Frame-valid generation for triggered start-and-stop scanning with trailing lines,
// max-line stop and a selectable external or brightness trigger source.
// Assumes line_pulse and pixels on clk; trigger pins are asynchronous.
//
// Overview of operation
// - In start-stop mode add programmed trailing lines, 0 to 65535, after stop.
// - With max-line stop on, end frame at max line count lacking stop edge.
// - Max-line stop acts only in start-and-stop mode.
// - Max line count is 1 to 65535, used only in start-stop with option.
// - Region mean brightness crossing a threshold starts or stops the frame.
// - Trigger source selects external inputs or internal; all support debouncing.
// - Internal trigger follows scan mode and selected edge polarity.
// - Region start pixel is at least 1, used only with internal source.
// - Scan mode selects free-running, start only, reserved, start-and-stop.
// - Start-stop frame valid follows trigger after start delay, length by pulse.
// - Rising and falling thresholds are each 1 to 254.
// - Region length selects 32, 64, 128 or 256 pixels.
module frame_trigger_ctrl (
  input  wire logic                              clk,
  input  wire logic                              arst_n,
  input  wire logic [frame_sync_pkg::ADDR_W-1:0] addr,
  input  wire logic [frame_sync_pkg::DATA_W-1:0] wdata,
  input  wire logic                              wr,
  input  wire logic                              rd,
  output logic [frame_sync_pkg::DATA_W-1:0]      rdata_q,
  input  wire logic                              line_pulse,
  input  wire frame_sync_pkg::pixel_t            pix,
  input  wire logic [frame_sync_pkg::NSRC-2:0]   trig_pins,
  input  wire logic [frame_sync_pkg::LINE_W-1:0] start_delay,
  input  wire logic [frame_sync_pkg::LINE_W-1:0] scan_lines,
  output logic                                   fval_q
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_DELAY, ST_ACTIVE, ST_TRAIL, ST_WAIT_REL
  } fstate_t;

  frame_sync_pkg::ctrl_t             ctrl_q, ctrl_d;
  logic [frame_sync_pkg::LINE_W-1:0] after_q, after_d;
  logic [frame_sync_pkg::LINE_W-1:0] maxl_q, maxl_d;
  logic [frame_sync_pkg::LINE_W-1:0] roi_start_q, roi_start_d;
  frame_sync_pkg::roi_len_t          roi_len_q, roi_len_d;
  logic [frame_sync_pkg::PIX_W-1:0]  rise_q, rise_d;
  logic [frame_sync_pkg::PIX_W-1:0]  fall_q, fall_d;
  logic [frame_sync_pkg::DATA_W-1:0] rdata_d;
  logic [frame_sync_pkg::NSRC-2:0]   sync1_q, sync2_q;
  logic                              bright;
  logic [frame_sync_pkg::PIX_W-1:0]  mean;
  logic                              raw_trig;
  logic                              deb_q, deb_d;
  logic [3:0]                        deb_cnt_q, deb_cnt_d;
  logic [3:0]                        deb_len;
  logic                              trig_prev_q, trig_prev_d;
  logic                              trig_act;
  fstate_t                           st_q, st_d;
  logic [frame_sync_pkg::LINE_W-1:0] cnt_q, cnt_d;
  logic [frame_sync_pkg::LINE_W-1:0] lines_q, lines_d;
  logic                              fval_d;
  logic [frame_sync_pkg::LINE_W-1:0] wlo;

  roi_brightness u_roi (
    .clk        (clk),
    .arst_n     (arst_n),
    .pix        (pix),
    .roi_start  (roi_start_q),
    .roi_len    (roi_len_q),
    .rise_level (rise_q),
    .fall_level (fall_q),
    .bright_q   (bright),
    .mean_q     (mean)
  );

  // Register port.
  always_comb begin
    ctrl_d      = ctrl_q;
    after_d     = after_q;
    maxl_d      = maxl_q;
    roi_start_d = roi_start_q;
    roi_len_d   = roi_len_q;
    rise_d      = rise_q;
    fall_d      = fall_q;
    rdata_d     = '0;
    wlo         = wdata[frame_sync_pkg::LINE_W-1:0];
    if (wr) begin
      case (addr)
        frame_sync_pkg::REG_CTRL:  ctrl_d = frame_sync_pkg::ctrl_t'(wdata[8:0]);
        frame_sync_pkg::REG_AFTER: after_d = wlo;
        frame_sync_pkg::REG_MAXLINES: maxl_d = (wlo == 16'h0000) ? 16'h0001 : wlo;
        frame_sync_pkg::REG_ROI: begin
          roi_start_d = (wlo == 16'h0000) ? 16'h0001 : wlo;
          roi_len_d   = frame_sync_pkg::roi_len_t'(wdata[17:16]);
        end
        frame_sync_pkg::REG_LEVELS: begin
          rise_d = (wdata[7:0] < frame_sync_pkg::LEVEL_MIN) ? frame_sync_pkg::LEVEL_MIN :
                   (wdata[7:0] > frame_sync_pkg::LEVEL_MAX) ? frame_sync_pkg::LEVEL_MAX :
                   wdata[7:0];
          fall_d = (wdata[15:8] < frame_sync_pkg::LEVEL_MIN) ? frame_sync_pkg::LEVEL_MIN :
                   (wdata[15:8] > frame_sync_pkg::LEVEL_MAX) ? frame_sync_pkg::LEVEL_MAX :
                   wdata[15:8];
        end
        default: ;
      endcase
    end
    if (rd) begin
      case (addr)
        frame_sync_pkg::REG_CTRL:     rdata_d = {23'h000000, ctrl_q};
        frame_sync_pkg::REG_AFTER:    rdata_d = {16'h0000, after_q};
        frame_sync_pkg::REG_MAXLINES: rdata_d = {16'h0000, maxl_q};
        frame_sync_pkg::REG_ROI:      rdata_d = {14'h0000, roi_len_q, roi_start_q};
        frame_sync_pkg::REG_LEVELS:   rdata_d = {16'h0000, fall_q, rise_q};
        frame_sync_pkg::REG_STATUS:
          rdata_d = {5'h00, mean, lines_q[15:0], fval_q, bright, deb_q};
        default:                      rdata_d = '0;
      endcase
    end
  end

  // Trigger source select and line-based debounce.
  always_comb begin
    if (ctrl_q.source == frame_sync_pkg::SRC_INTERNAL) begin
      raw_trig = bright;
    end else if (ctrl_q.source < frame_sync_pkg::SRC_INTERNAL) begin
      raw_trig = sync2_q[ctrl_q.source[1:0]];
    end else begin
      raw_trig = sync2_q[frame_sync_pkg::NSRC-2];
    end
    case (ctrl_q.debounce)
      2'h0:    deb_len = frame_sync_pkg::DEB_LEN0;
      2'h1:    deb_len = frame_sync_pkg::DEB_LEN1;
      2'h2:    deb_len = frame_sync_pkg::DEB_LEN2;
      default: deb_len = frame_sync_pkg::DEB_LEN3;
    endcase
    deb_d     = deb_q;
    deb_cnt_d = deb_cnt_q;
    if (raw_trig == deb_q) begin
      deb_cnt_d = 4'h0;
    end else if (deb_len == 4'h0) begin
      deb_d = raw_trig;
    end else if (line_pulse) begin
      deb_cnt_d = deb_cnt_q + 4'h1;
      if (deb_cnt_d >= deb_len) begin
        deb_d     = raw_trig;
        deb_cnt_d = 4'h0;
      end
    end
    trig_act    = deb_q ^ ctrl_q.trig_low_active;
    trig_prev_d = trig_act;
  end

  // Frame state machine; delay, active and trailing states advance on line pulses.
  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    lines_d = lines_q;
    fval_d  = fval_q;
    case (st_q)
      ST_IDLE: begin
        fval_d = 1'b0;
        if (ctrl_q.mode == frame_sync_pkg::MODE_FREE ||
            (trig_act && !trig_prev_q && (ctrl_q.mode == frame_sync_pkg::MODE_START ||
                                         ctrl_q.mode == frame_sync_pkg::MODE_SS))) begin
          st_d  = ST_DELAY;
          cnt_d = '0;
        end
      end
      ST_DELAY: if (line_pulse) begin
        if (cnt_q >= start_delay) begin
          st_d    = ST_ACTIVE;
          fval_d  = 1'b1;
          lines_d = 16'h0001;
        end else begin
          cnt_d = cnt_q + 16'h0001;
        end
      end
      ST_ACTIVE: if (line_pulse) begin
        lines_d = lines_q + 16'h0001;
        if (ctrl_q.mode == frame_sync_pkg::MODE_SS) begin
          if (!trig_act) begin
            st_d  = (after_q == 16'h0000) ? ST_IDLE : ST_TRAIL;
            cnt_d = 16'h0001;
            fval_d = (after_q != 16'h0000);
          end else if (ctrl_q.max_stop_en && lines_q >= maxl_q) begin
            st_d   = ST_WAIT_REL;
            fval_d = 1'b0;
          end
        end else if (lines_q >= scan_lines) begin
          st_d   = ST_IDLE;
          fval_d = 1'b0;
        end
      end
      ST_TRAIL: if (line_pulse) begin
        if (cnt_q >= after_q) begin
          st_d   = ST_IDLE;
          fval_d = 1'b0;
        end else begin
          cnt_d = cnt_q + 16'h0001;
        end
      end
      ST_WAIT_REL: begin
        fval_d = 1'b0;
        if (!trig_act) begin
          st_d = ST_IDLE;
        end
      end
      default: begin
        st_d   = ST_IDLE;
        fval_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q      <= '0;
      after_q     <= '0;
      maxl_q      <= frame_sync_pkg::MAXLINES_RST;
      roi_start_q <= frame_sync_pkg::ROI_START_RST;
      roi_len_q   <= frame_sync_pkg::ROI_32;
      rise_q      <= frame_sync_pkg::RISE_RST;
      fall_q      <= frame_sync_pkg::FALL_RST;
      rdata_q     <= '0;
      sync1_q     <= '0;
      sync2_q     <= '0;
      deb_q       <= 1'b0;
      deb_cnt_q   <= '0;
      trig_prev_q <= 1'b0;
      st_q        <= ST_IDLE;
      cnt_q       <= '0;
      lines_q     <= '0;
      fval_q      <= 1'b0;
    end else begin
      ctrl_q      <= ctrl_d;
      after_q     <= after_d;
      maxl_q      <= maxl_d;
      roi_start_q <= roi_start_d;
      roi_len_q   <= roi_len_d;
      rise_q      <= rise_d;
      fall_q      <= fall_d;
      rdata_q     <= rdata_d;
      sync1_q     <= trig_pins;
      sync2_q     <= sync1_q;
      deb_q       <= deb_d;
      deb_cnt_q   <= deb_cnt_d;
      trig_prev_q <= trig_prev_d;
      st_q        <= st_d;
      cnt_q       <= cnt_d;
      lines_q     <= lines_d;
      fval_q      <= fval_d;
    end
  end

endmodule

//--- hdl/roi_brightness.sv
// Region brightness trigger: averages region pixels per line, compares with thresholds.
// Assumes pixels arrive on the same clock, counted from 1 after each line start.
module roi_brightness (
  input  wire logic                              clk,
  input  wire logic                              arst_n,
  input  wire frame_sync_pkg::pixel_t            pix,
  input  wire logic [frame_sync_pkg::LINE_W-1:0] roi_start,
  input  wire frame_sync_pkg::roi_len_t          roi_len,
  input  wire logic [frame_sync_pkg::PIX_W-1:0]  rise_level,
  input  wire logic [frame_sync_pkg::PIX_W-1:0]  fall_level,
  output logic                                   bright_q,
  output logic [frame_sync_pkg::PIX_W-1:0]       mean_q
);

  logic [frame_sync_pkg::LINE_W-1:0] pos_q, pos_d;
  logic [frame_sync_pkg::ACC_W-1:0]  acc_q, acc_d;
  logic [8:0]                        left_q, left_d;
  logic                              bright_d;
  logic [frame_sync_pkg::PIX_W-1:0]  mean_d;
  logic [8:0]                        len;
  logic [frame_sync_pkg::PIX_W-1:0]  avg;
  logic [frame_sync_pkg::ACC_W-1:0]  sum;

  always_comb begin
    case (roi_len)
      frame_sync_pkg::ROI_32:  len = 9'h020;
      frame_sync_pkg::ROI_64:  len = 9'h040;
      frame_sync_pkg::ROI_128: len = 9'h080;
      default:                 len = 9'h100;
    endcase
  end

  always_comb begin
    pos_d    = pos_q;
    acc_d    = acc_q;
    left_d   = left_q;
    bright_d = bright_q;
    mean_d   = mean_q;
    sum      = acc_q + {8'h00, pix.data};
    case (roi_len)
      frame_sync_pkg::ROI_32:  avg = sum[12:5];
      frame_sync_pkg::ROI_64:  avg = sum[13:6];
      frame_sync_pkg::ROI_128: avg = sum[14:7];
      default:                 avg = sum[15:8];
    endcase
    if (pix.valid) begin
      pos_d = pix.line_start ? 16'h0001 : pos_q + 16'h0001;
      if (pos_d == roi_start) begin
        acc_d  = {8'h00, pix.data};
        left_d = len - 9'h001;
      end else if (left_q != 9'h000) begin
        acc_d  = sum;
        left_d = left_q - 9'h001;
        if (left_q == 9'h001) begin
          mean_d = avg;
          if (avg >= rise_level) begin
            bright_d = 1'b1;
          end else if (avg <= fall_level) begin
            bright_d = 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pos_q    <= '0;
      acc_q    <= '0;
      left_q   <= '0;
      bright_q <= 1'b0;
      mean_q   <= '0;
    end else begin
      pos_q    <= pos_d;
      acc_q    <= acc_d;
      left_q   <= left_d;
      bright_q <= bright_d;
      mean_q   <= mean_d;
    end
  end

endmodule

//--- tb/frame_trigger_ctrl_assertions.sv
// Checker for the frame trigger block: register answers and frame-valid timing.
// Assumes one clock domain and the bind at the foot; sees top-level ports only.
module frame_trigger_ctrl_assertions (
  input wire logic                              clk,
  input wire logic                              arst_n,
  input wire logic [frame_sync_pkg::ADDR_W-1:0] addr,
  input wire logic [frame_sync_pkg::DATA_W-1:0] wdata,
  input wire logic                              wr,
  input wire logic                              rd,
  input wire logic [frame_sync_pkg::DATA_W-1:0] rdata_q,
  input wire logic                              line_pulse,
  input wire logic                              fval_q
);
  logic [1:0]  mode_q;
  logic [31:0] wd_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Tracks the last written mode and write data.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= 2'h0;
      wd_q   <= 32'h0;
    end else if (wr) begin
      wd_q <= wdata;
      if (addr == frame_sync_pkg::REG_CTRL) begin
        mode_q <= wdata[1:0];
      end
    end
  end
  a_levels_clamp: assert property (rd && addr == frame_sync_pkg::REG_LEVELS |=>
    rdata_q[7:0] inside {[8'h01:8'hfe]} && rdata_q[15:8] inside {[8'h01:8'hfe]})
    else $error("threshold outside its range");
  a_maxl_min: assert property (rd && addr == frame_sync_pkg::REG_MAXLINES |=>
    rdata_q[15:0] != 16'h0) else $error("max line count read as zero");
  a_roi_min: assert property (rd && addr == frame_sync_pkg::REG_ROI |=>
    rdata_q[15:0] != 16'h0) else $error("region start read as zero");
  a_roi_len: assert property (wr && addr == frame_sync_pkg::REG_ROI ##1
    rd && addr == frame_sync_pkg::REG_ROI |=> rdata_q[17:16] == wd_q[17:16])
    else $error("region length not kept");
  a_ctrl_back: assert property (wr && addr == frame_sync_pkg::REG_CTRL ##1
    rd && addr == frame_sync_pkg::REG_CTRL |=> rdata_q[8:0] == wd_q[8:0])
    else $error("control fields not kept");
  a_maxl_back: assert property (wr && addr == frame_sync_pkg::REG_MAXLINES &&
    wdata[15:0] != 16'h0 ##1 rd && addr == frame_sync_pkg::REG_MAXLINES |=>
    rdata_q[15:0] == wd_q[15:0]) else $error("max line count not kept");
  a_after_back: assert property (wr && addr == frame_sync_pkg::REG_AFTER ##1
    rd && addr == frame_sync_pkg::REG_AFTER |=> rdata_q[15:0] == wd_q[15:0])
    else $error("trailing line count not kept");
  a_rsvd_idle: assert property (mode_q == 2'h2 && !fval_q |=> !fval_q)
    else $error("frame started in reserved mode");
  a_fval_line: assert property ($changed(fval_q) && !$past(wr) |->
    $past(line_pulse)) else $error("frame valid moved off a line pulse");
endmodule

bind frame_trigger_ctrl frame_trigger_ctrl_assertions u_chk (.clk(clk), .arst_n(arst_n),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
  .line_pulse(line_pulse), .fval_q(fval_q));

//--- tb/line_source.sv
// Line timing and pixel source for the sensor side of the block.
// Assumes one clock; the bench sets the pixel level, taken up at once.
module line_source #(
  parameter int LINE_CYC = 90,
  parameter int LINE_PIX = 80
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic [7:0]       level,
  output logic                  line_pulse,
  output frame_sync_pkg::pixel_t pix
);
  int cnt_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 0;
    end else begin
      cnt_q <= (cnt_q == LINE_CYC - 1) ? 0 : cnt_q + 1;
    end
  end
  assign line_pulse = arst_n && (cnt_q == 0);
  logic on_pix;
  assign on_pix = (cnt_q >= 1) && (cnt_q <= LINE_PIX);
  // two taps of 40 pixels; the region stays in the front one.
  assign pix = '{valid: on_pix, line_start: (cnt_q == 1), data: on_pix ? level : ~level};
endmodule

//--- tb/tb_line_scan_frame_trigger_control.sv
// Testbench for the frame trigger block: a table of frame cases, then hand tests.
// Assumes the line source model feeds lines and pixels; registers on the strobe port.
module tb_line_scan_frame_trigger_control;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [2:0]  src;
    logic        low;
    logic [1:0]  deb;
    logic [15:0] aft;
    logic [15:0] mx;
    int          act;
    int          delta;
  } row_t;
  row_t rows[11] = '{
    '{3'h0, 1'h0, 2'h0, 16'h0, 16'h0, 5, 0}, '{3'h0, 1'h0, 2'h0, 16'h3, 16'h0, 5, 3},
    '{3'h0, 1'h0, 2'h0, 16'h0, 16'h0, 8, 3}, '{3'h0, 1'h0, 2'h1, 16'h0, 16'h0, 5, 0},
    '{3'h0, 1'h0, 2'h2, 16'h0, 16'h0, 5, 0}, '{3'h0, 1'h0, 2'h3, 16'h0, 16'h0, 10, 5},
    '{3'h0, 1'h1, 2'h0, 16'h0, 16'h0, 5, 0}, '{3'h4, 1'h0, 2'h0, 16'h0, 16'h0, 5, 0},
    '{3'h4, 1'h1, 2'h0, 16'h0, 16'h0, 5, 0}, '{3'h4, 1'h0, 2'h0, 16'h2, 16'h0, 6, 3},
    '{3'h0, 1'h0, 2'h0, 16'h0, 16'h64, 5, 0}};
  logic                   clk;
  logic                   arst_n;
  logic [3:0]             addr;
  logic [31:0]            wdata;
  logic                   wr;
  logic                   rd;
  logic [31:0]            rdata_q;
  logic                   line_pulse;
  frame_sync_pkg::pixel_t pix;
  logic [4:0]             trig_pins;
  logic [15:0]            start_delay;
  logic [15:0]            scan_lines;
  logic                   fval_q;
  logic [7:0]             level;
  logic                   low;
  logic [31:0]            c;
  int                     n_fail;
  int                     compares;
  int                     fl;
  int                     base;
  int                     l1;
  int                     l2;
  int                     res;

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  frame_trigger_ctrl DUT (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata_q(rdata_q), .line_pulse(line_pulse), .pix(pix), .trig_pins(trig_pins),
    .start_delay(start_delay), .scan_lines(scan_lines), .fval_q(fval_q));
  line_source u_src (.clk(clk), .arst_n(arst_n), .level(level), .line_pulse(line_pulse),
    .pix(pix));

  task automatic summarize();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rchk(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk("register", e, rdata_q & m);
    @(posedge clk);
  endtask

  task automatic cfg(input logic [3:0] a, input logic [31:0] d, input logic [31:0] e,
                     input logic [31:0] m);
    wreg(a, d);
    rchk(a, e, m);
  endtask

  task automatic lines(input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (line_pulse !== 1'b1 && k < 200);
      if (k >= 200) begin
        n_fail++;
        summarize();
      end
      if (fval_q === 1'b1) fl++;
    end
  endtask

  task automatic act(input logic on);
    trig_pins <= {4'h0, on ^ low};
    level <= (on ^ low) ? 8'hc8 : 8'h14;
  endtask

  task automatic run(input int n, output int r);
    act(1'b0);
    lines(20);
    fl = 0;
    act(1'b1);
    lines(n);
    act(1'b0);
    lines(16);
    chk("frame end", 32'h0, {31'h0, fval_q});
    r = fl;
  endtask

  initial begin
    arst_n = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    trig_pins = 5'h00;
    // start delay is zero wherever trailing lines are used, so no correction is needed.
    start_delay = 16'h0000;
    scan_lines = 16'h0006;
    level = 8'h14;
    low = 1'b0;
    n_fail = 0;
    compares = 0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    cfg(frame_sync_pkg::REG_ROI, 32'h1, 32'h1, 32'h3ffff);
    foreach (rows[i]) begin
      low = rows[i].low;
      c = {23'h0, rows[i].low, rows[i].mx != 16'h0, rows[i].deb, rows[i].src, 2'h3};
      cfg(frame_sync_pkg::REG_AFTER, rows[i].aft, rows[i].aft, 32'hffff);
      // the max count is set well above the object length.
      if (rows[i].mx != 16'h0) cfg(frame_sync_pkg::REG_MAXLINES, rows[i].mx, rows[i].mx, 32'hffff);
      cfg(frame_sync_pkg::REG_CTRL, c, c, 32'h1ff);
      run(rows[i].act, res);
      if (i == 0) base = res;
      chk("frame lines", base + rows[i].delta, res);
      $display("test row %0d done", i);
    end
    low = 1'b0;
    cfg(frame_sync_pkg::REG_AFTER, 32'h0, 32'h0, 32'hffff);
    cfg(frame_sync_pkg::REG_MAXLINES, 32'h4, 32'h4, 32'hffff);
    cfg(frame_sync_pkg::REG_CTRL, 32'h83, 32'h83, 32'h1ff);
    run(20, l1);
    cfg(frame_sync_pkg::REG_MAXLINES, 32'h7, 32'h7, 32'hffff);
    run(20, l2);
    chk("max stop step", 32'h3, l2 - l1);
    chk("max stop cut", 32'h1, {31'h0, l2 < base + 15});
    start_delay <= 16'h0003;
    run(5, res);
    chk("start delay", base - 3, res);
    start_delay <= 16'h0000;
    $display("test max stop done");
    cfg(frame_sync_pkg::REG_MAXLINES, 32'h2, 32'h2, 32'hffff);
    cfg(frame_sync_pkg::REG_CTRL, 32'h81, 32'h81, 32'h1ff);
    run(3, l1);
    run(6, l2);
    cfg(frame_sync_pkg::REG_CTRL, 32'h01, 32'h01, 32'h1ff);
    run(6, res);
    chk("start only length", l1, l2);
    chk("max stop ignored", res, l2);
    cfg(frame_sync_pkg::REG_CTRL, 32'h02, 32'h02, 32'h1ff);
    run(5, res);
    chk("reserved idle", 32'h0, res);
    cfg(frame_sync_pkg::REG_CTRL, 32'h00, 32'h00, 32'h1ff);
    fl = 0;
    lines(20);
    chk("free running", 32'h1, {31'h0, fl > 0});
    rchk(frame_sync_pkg::REG_STATUS, 32'h00a00000, 32'h07f80003);
    $display("test modes done");
    arst_n <= 1'b0;
    @(negedge clk);
    chk("reset fval", 32'h0, {31'h0, fval_q});
    chk("reset rdata", 32'h0, rdata_q);
    @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rchk(frame_sync_pkg::REG_MAXLINES, 32'hffff, 32'hffff);
    rchk(frame_sync_pkg::REG_ROI, 32'h1, 32'h3ffff);
    rchk(frame_sync_pkg::REG_LEVELS, 32'h4080, 32'hffff);
    rchk(4'hf, 32'h0, 32'hffffffff);
    cfg(frame_sync_pkg::REG_MAXLINES, 32'h0, 32'h1, 32'hffff);
    cfg(frame_sync_pkg::REG_ROI, 32'h0, 32'h1, 32'hffff);
    cfg(frame_sync_pkg::REG_ROI, 32'h30001, 32'h30001, 32'h3ffff);
    cfg(frame_sync_pkg::REG_LEVELS, 32'hff00, 32'hfe01, 32'hffff);
    $display("test reset and registers done");
    summarize();
  end
endmodule
